//--- verilog/frtt_timers.sv
// free running 10 ms / 100 ms tick counters and program stamp words
// assumes an APB master on the system clock and a calendar source
// that presents valid BCD time whenever prog_write pulses
//
// Summary of operation
// - fast word starts zero, counts 10 ms
// - fast word wraps FFFF to zero silently
// - slow word starts zero, counts 100 ms
// - slow word wraps FFFF to zero silently
// - mode changes never clear or pause counters
// - program overwrite stores BCD date and time
// - first two words: sec, min, hour, day
// - third word: month low, year high
// - fourth word low byte: weekday 00-06
//
// Added by the designer: the APB register port.

`timescale 1ns/100ps

module frtt_timers
#(
   parameter logic [frtt_pkg::PRE_W-1:0] TICK_CYCLES = frtt_pkg::FAST_CYCLES
)
(
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   input  wire frtt_pkg::frtt_apb_req_t apb_req,
   output frtt_pkg::frtt_apb_rsp_t      apb_rsp,
   input  wire logic                    prog_write,
   input  wire frtt_pkg::frtt_cal_t     cal_now
);
   import frtt_pkg::*;

   frtt_state_t      st_q;
   frtt_state_t      st_d;
   logic             fast_tick;
   logic             slow_tick;
   logic [NFLD-1:0]  fld_ok;
   logic             cal_ok;
   logic             capture;
   logic             setup;
   logic [9:0]       idx;

   // ------------------------------------------------------------
   // calendar check
   // ------------------------------------------------------------
   function automatic logic bcd_ok(input logic [7:0] b,
                                   input logic [7:0] lo,
                                   input logic [7:0] hi);
      bcd_ok = (b[3:0] <= 4'h9) && (b[7:4] <= 4'h9) && (b >= lo) && (b <= hi);
   endfunction

   // a malformed calendar would leave an unreadable stamp, so it is refused
   for (genvar i = 0; i < NFLD; i++)
   begin : g_fld
      assign fld_ok[i] = bcd_ok(cal_now[i*8 +: 8], FLD_LO[i*8 +: 8],
                                FLD_HI[i*8 +: 8]);
   end

   assign cal_ok    = &fld_ok;
   assign capture   = prog_write && cal_ok;
   assign fast_tick = (st_q.pre == PRE_W'(TICK_CYCLES - 1));
   assign slow_tick = fast_tick && (st_q.dec == SLOW_DIV - 4'h1);
   assign setup     = apb_req.psel && !apb_req.penable;
   assign idx       = apb_req.paddr[ADDR_W-1:2];

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      // no mode input exists: only power-on reset clears the words
      st_d.pre = fast_tick ? '0 : st_q.pre + 1'b1;
      if (fast_tick)
      begin
         st_d.fast = st_q.fast + 16'h0001;
         st_d.dec  = (st_q.dec == SLOW_DIV - 4'h1) ? 4'h0 : st_q.dec + 4'h1;
      end
      if (slow_tick)
      begin
         st_d.slow = st_q.slow + 16'h0001;
      end
      if (capture)
      begin
         st_d.stamp = cal_now;
      end

      // answer is prepared in the setup cycle, so every access is one wait-free
      st_d.rsp.pready  = setup;
      st_d.rsp.pslverr = 1'b0;
      st_d.rsp.prdata  = 32'h0000_0000;
      if (setup)
      begin
         if (apb_req.pwrite || apb_req.paddr[1:0] != 2'h0)
         begin
            st_d.rsp.pslverr = 1'b1;
         end
         else
         begin
            unique case (idx)
               IDX_FAST:
                  st_d.rsp.prdata = {16'h0000, st_q.fast};
               IDX_SLOW:
                  st_d.rsp.prdata = {16'h0000, st_q.slow};
               IDX_STMP1:
                  st_d.rsp.prdata = {16'h0000, st_q.stamp.minute,
                                     st_q.stamp.second};
               IDX_STMP2:
                  st_d.rsp.prdata = {16'h0000, st_q.stamp.day,
                                     st_q.stamp.hour};
               IDX_STMP3:
                  st_d.rsp.prdata = {16'h0000, st_q.stamp.year,
                                     st_q.stamp.month};
               IDX_STMP4:
                  st_d.rsp.prdata = {24'h00_0000, st_q.stamp.weekday};
               default:
                  st_d.rsp.pslverr = 1'b1;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   // the stamp needs battery-backed storage to outlive power loss;
   // here it survives everything except rst_n
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q       <= '0;
         st_q.fast  <= TICK_RST;
         st_q.slow  <= TICK_RST;
         st_q.stamp <= STAMP_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign apb_rsp = st_q.rsp;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_fast_step;
      @(posedge clock) disable iff (!rst_n)
      fast_tick |=> st_q.fast == $past(st_q.fast) + 16'h0001;
   endproperty
   a_fast_step: assert property (p_fast_step)
      else $error("fast word did not step on tick");

   property p_fast_still;
      @(posedge clock) disable iff (!rst_n)
      !fast_tick |=> $stable(st_q.fast) && $stable(st_q.slow);
   endproperty
   a_fast_still: assert property (p_fast_still)
      else $error("tick word moved without a tick");

   property p_fast_wrap;
      @(posedge clock) disable iff (!rst_n)
      fast_tick && st_q.fast == TICK_TOP |=> st_q.fast == TICK_RST;
   endproperty
   a_fast_wrap: assert property (p_fast_wrap)
      else $error("fast word wrap wrong");

   property p_slow_step;
      @(posedge clock) disable iff (!rst_n)
      slow_tick |=> st_q.slow == $past(st_q.slow) + 16'h0001;
   endproperty
   a_slow_step: assert property (p_slow_step)
      else $error("slow word did not step");

   property p_slow_ratio;
      @(posedge clock) disable iff (!rst_n)
      fast_tick && st_q.dec != SLOW_DIV - 4'h1 |=> $stable(st_q.slow);
   endproperty
   a_slow_ratio: assert property (p_slow_ratio)
      else $error("slow word stepped early");

   property p_slow_wrap;
      @(posedge clock) disable iff (!rst_n)
      slow_tick && st_q.slow == TICK_TOP |=> st_q.slow == TICK_RST;
   endproperty
   a_slow_wrap: assert property (p_slow_wrap)
      else $error("slow word wrap wrong");

   property p_no_clear;
      @(posedge clock) disable iff (!rst_n)
      st_q.fast != TICK_RST && st_q.fast != TICK_TOP |=> st_q.fast != TICK_RST;
   endproperty
   a_no_clear: assert property (p_no_clear)
      else $error("fast word cleared outside reset");

   property p_capture;
      @(posedge clock) disable iff (!rst_n)
      capture ##1 !capture ##1 setup && idx == IDX_STMP1 && !apb_req.pwrite
      && apb_req.paddr[1:0] == 2'h0
      |=> apb_rsp.prdata[15:0] == {$past(cal_now.minute, 3),
                                  $past(cal_now.second, 3)};
   endproperty
   a_capture: assert property (p_capture)
      else $error("stamp not stored or read back wrong");

   property p_ranges;
      @(posedge clock) disable iff (!rst_n)
      1'b1 |-> st_q.stamp.month >= 8'h01 && st_q.stamp.month <= 8'h12
      && st_q.stamp.day >= 8'h01 && st_q.stamp.hour <= 8'h23;
   endproperty
   a_ranges: assert property (p_ranges)
      else $error("stamp field out of range");

   property p_weekday;
      @(posedge clock) disable iff (!rst_n)
      setup && idx == IDX_STMP4 && !apb_req.pwrite
      |=> apb_rsp.pready && apb_rsp.prdata <= 32'h0000_0006;
   endproperty
   a_weekday: assert property (p_weekday)
      else $error("weekday word out of range");

   property p_stamp_hold;
      @(posedge clock) disable iff (!rst_n)
      !capture |=> $stable(st_q.stamp);
   endproperty
   a_stamp_hold: assert property (p_stamp_hold)
      else $error("stamp changed without overwrite");

   property p_fast_once;
      @(posedge clock) disable iff (!rst_n)
      fast_tick |=> !fast_tick;
   endproperty
   a_fast_once: assert property (p_fast_once)
      else $error("fast tick lasted more than one cycle");

   property p_pre_range;
      @(posedge clock) disable iff (!rst_n)
      1'b1 |-> st_q.pre < TICK_CYCLES;
   endproperty
   a_pre_range: assert property (p_pre_range)
      else $error("prescaler beyond tick period");

   property p_slow_with_fast;
      @(posedge clock) disable iff (!rst_n)
      $changed(st_q.slow) |-> $changed(st_q.fast);
   endproperty
   a_slow_with_fast: assert property (p_slow_with_fast)
      else $error("slow word moved apart from a fast tick");

   property p_dec_range;
      @(posedge clock) disable iff (!rst_n)
      1'b1 |-> st_q.dec < SLOW_DIV;
   endproperty
   a_dec_range: assert property (p_dec_range)
      else $error("decade counter out of range");

   property p_ready_next;
      @(posedge clock) disable iff (!rst_n)
      setup |=> apb_rsp.pready;
   endproperty
   a_ready_next: assert property (p_ready_next)
      else $error("no ready after setup");

   property p_ready_cause;
      @(posedge clock) disable iff (!rst_n)
      !setup |=> !apb_rsp.pready;
   endproperty
   a_ready_cause: assert property (p_ready_cause)
      else $error("ready without setup");

   property p_quiet_bus;
      @(posedge clock) disable iff (!rst_n)
      !apb_rsp.pready |-> apb_rsp.prdata == 32'h0000_0000 && !apb_rsp.pslverr;
   endproperty
   a_quiet_bus: assert property (p_quiet_bus)
      else $error("response lines busy outside access");

   property p_read_fast;
      @(posedge clock) disable iff (!rst_n)
      setup && !apb_req.pwrite && apb_req.paddr == {IDX_FAST, 2'h0}
      |=> apb_rsp.prdata == {16'h0000, $past(st_q.fast)} && !apb_rsp.pslverr;
   endproperty
   a_read_fast: assert property (p_read_fast)
      else $error("fast word read back wrong");

   property p_read_slow;
      @(posedge clock) disable iff (!rst_n)
      setup && !apb_req.pwrite && apb_req.paddr == {IDX_SLOW, 2'h0}
      |=> apb_rsp.prdata == {16'h0000, $past(st_q.slow)} && !apb_rsp.pslverr;
   endproperty
   a_read_slow: assert property (p_read_slow)
      else $error("slow word read back wrong");

   property p_read_sec_min;
      @(posedge clock) disable iff (!rst_n)
      setup && !apb_req.pwrite && apb_req.paddr == {IDX_STMP1, 2'h0}
      |=> apb_rsp.prdata == {16'h0000, $past(st_q.stamp.minute), $past(st_q.stamp.second)};
   endproperty
   a_read_sec_min: assert property (p_read_sec_min)
      else $error("first stamp word read back wrong");

   property p_read_hour_day;
      @(posedge clock) disable iff (!rst_n)
      setup && !apb_req.pwrite && apb_req.paddr == {IDX_STMP2, 2'h0}
      |=> apb_rsp.prdata == {16'h0000, $past(st_q.stamp.day), $past(st_q.stamp.hour)};
   endproperty
   a_read_hour_day: assert property (p_read_hour_day)
      else $error("second stamp word read back wrong");

   property p_read_month_year;
      @(posedge clock) disable iff (!rst_n)
      setup && !apb_req.pwrite && apb_req.paddr == {IDX_STMP3, 2'h0}
      |=> apb_rsp.prdata == {16'h0000, $past(st_q.stamp.year), $past(st_q.stamp.month)};
   endproperty
   a_read_month_year: assert property (p_read_month_year)
      else $error("third stamp word read back wrong");

   property p_write_refused;
      @(posedge clock) disable iff (!rst_n)
      setup && apb_req.pwrite |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000;
   endproperty
   a_write_refused: assert property (p_write_refused)
      else $error("write not refused");

   property p_misaligned;
      @(posedge clock) disable iff (!rst_n)
      setup && apb_req.paddr[1:0] != 2'h0 |=> apb_rsp.pslverr;
   endproperty
   a_misaligned: assert property (p_misaligned)
      else $error("misaligned access not refused");

   property p_stamp_take;
      @(posedge clock) disable iff (!rst_n)
      capture |=> st_q.stamp == $past(cal_now);
   endproperty
   a_stamp_take: assert property (p_stamp_take)
      else $error("stamp not taken on overwrite");

   property p_bad_cal;
      @(posedge clock) disable iff (!rst_n)
      prog_write && !cal_ok |=> $stable(st_q.stamp);
   endproperty
   a_bad_cal: assert property (p_bad_cal)
      else $error("malformed calendar reached the stamp");

   property p_clock_range;
      @(posedge clock) disable iff (!rst_n)
      1'b1 |-> st_q.stamp.second <= 8'h59 && st_q.stamp.minute <= 8'h59
      && st_q.stamp.year <= 8'h99 && st_q.stamp.day <= 8'h31;
   endproperty
   a_clock_range: assert property (p_clock_range)
      else $error("stamp time field out of range");

   property p_weekday_range;
      @(posedge clock) disable iff (!rst_n)
      1'b1 |-> st_q.stamp.weekday <= 8'h06;
   endproperty
   a_weekday_range: assert property (p_weekday_range)
      else $error("stored weekday out of range");

endmodule

//--- shared/frtt_pkg.sv
// package for the free running tick timers: constants, bus carriers, state
// assumes a 40 MHz system clock and a 32-bit APB master

package frtt_pkg;

   // ------------------------------------------------------------
   // time base
   // ------------------------------------------------------------
   localparam int CLK_HZ    = 40_000_000;
   localparam int FAST_MS   = 10;
   localparam int SLOW_MS   = 100;
   localparam int PRE_W     = 20;
   localparam int FAST_CYC  = (CLK_HZ / 1000) * FAST_MS;
   localparam logic [PRE_W-1:0] FAST_CYCLES = PRE_W'(FAST_CYC);
   localparam logic [3:0]       SLOW_DIV    = 4'(SLOW_MS / FAST_MS);

   // ------------------------------------------------------------
   // register map: printed indexes, byte address is four times
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [9:0] IDX_FAST  = 10'h000;
   localparam logic [9:0] IDX_SLOW  = 10'h001;
   localparam logic [9:0] IDX_STMP1 = 10'h05A;
   localparam logic [9:0] IDX_STMP2 = 10'h05B;
   localparam logic [9:0] IDX_STMP3 = 10'h05C;
   localparam logic [9:0] IDX_STMP4 = 10'h05D;

   localparam logic [15:0] TICK_RST = 16'h0000;
   localparam logic [15:0] TICK_TOP = 16'hFFFF;

   // ------------------------------------------------------------
   // calendar fields, BCD, seconds in the low byte
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] weekday;
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } frtt_cal_t;

   localparam int NFLD = 7;
   localparam logic [55:0] FLD_LO = 56'h00_00_01_01_00_00_00;
   localparam logic [55:0] FLD_HI = 56'h06_99_12_31_23_59_59;
   // stamp value at power-on: Saturday 2000-01-01 00:00:00
   localparam logic [55:0] STAMP_RST = 56'h06_00_01_01_00_00_00;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } frtt_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } frtt_apb_rsp_t;

   typedef struct packed {
      logic [PRE_W-1:0] pre;
      logic [3:0]       dec;
      logic [15:0]      fast;
      logic [15:0]      slow;
      frtt_cal_t        stamp;
      frtt_apb_rsp_t    rsp;
   } frtt_state_t;

endpackage

//--- bench/frtt_timers_test.sv
// self-checking bench for the free running tick timers
// assumes the design answers an APB read one cycle after setup
`timescale 1ns/100ps

module frtt_timers_test;
   import frtt_pkg::*;

   // short tick so the run stays brief; wrap is left to the design's assertions
   localparam int TC = 4;

   logic          clock      = 1'b0;
   logic          rst_n      = 1'b0;
   frtt_apb_req_t apb_req    = '0;
   frtt_apb_rsp_t apb_rsp;
   logic          prog_write = 1'b0;
   frtt_cal_t     cal_now    = '0;
   int            n_errors   = 0;
   int            cmp_count  = 0;
   int            cyc        = 0;
   logic [31:0]   rd;
   logic [31:0]   rd2;
   logic          err;
   int            t1;
   int            t2;

   frtt_timers #(.TICK_CYCLES(20'(TC))) u_frtt_timers
   (
      .clock      (clock),
      .rst_n      (rst_n),
      .apb_req    (apb_req),
      .apb_rsp    (apb_rsp),
      .prog_write (prog_write),
      .cal_now    (cal_now)
   );

   always #12.5 clock = ~clock;

   always @(posedge clock)
      cyc <= cyc + 1;

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // t is the launch edge count, so two reads can be spaced exactly
   task automatic apb(input logic wr, input logic [11:0] addr, output logic [31:0] data,
                      output logic slverr, output int t);
      int n;
      n = 0;
      @(posedge clock);
      t = cyc;
      apb_req.psel    <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite  <= wr;
      apb_req.paddr   <= addr;
      apb_req.pwdata  <= 32'hFFFF_FFFF;
      @(posedge clock);
      apb_req.penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (apb_rsp.pready !== 1'b1);
      chk("pready_wait", 32'(n), 32'h1);
      data = apb_rsp.prdata;
      slverr = apb_rsp.pslverr;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   task automatic rchk(input string name, input logic [11:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, rd, err, t1);
      chk(name, rd, exp);
      chk("slverr", {31'h0, err}, 32'h0);
   endtask

   task automatic rate(input string name, input logic [11:0] addr, input int gap,
                       input int per);
      apb(1'b0, addr, rd, err, t1);
      repeat (gap) @(posedge clock);
      apb(1'b0, addr, rd2, err, t2);
      chk(name, rd2 - rd, 32'((t2 - t1) / per));
   endtask

   task automatic stamp(input logic [55:0] v);
      @(posedge clock);
      prog_write <= 1'b1;
      cal_now    <= v;
      @(posedge clock);
      prog_write <= 1'b0;
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      // read at once, before the first tick lands
      rchk("fast_rst", 12'h000, 32'h0);
      rchk("slow_rst", 12'h004, 32'h0);
      rchk("stamp1_rst", 12'h168, 32'h0000_0000);
      rchk("stamp2_rst", 12'h16C, 32'h0000_0100);
      $display("test reset done");
      rate("fast_rate", 12'h000, 397, TC);
      rate("slow_rate", 12'h004, 3997, TC * 10);
      $display("test rate done");
      stamp(56'h06_99_12_31_23_59_37);
      rchk("stamp_sec_min", 12'h168, 32'h0000_5937);
      rchk("stamp_hour_day", 12'h16C, 32'h0000_3123);
      rchk("stamp_month_year", 12'h170, 32'h0000_9912);
      rchk("stamp_weekday", 12'h174, 32'h0000_0006);
      for (int d = 0; d < 7; d++)
      begin
         stamp({8'(d), 48'h00_01_01_00_00_00});
         rchk("weekday", 12'h174, {24'h0, 8'(d)});
      end
      rchk("low_sec_min", 12'h168, 32'h0000_0000);
      rchk("low_hour_day", 12'h16C, 32'h0000_0100);
      $display("test stamp done");
      // out-of-range fields must leave the old stamp alone
      stamp(56'h06_00_01_01_00_05_60);
      stamp(56'h07_00_01_01_00_05_00);
      stamp(56'h06_05_13_01_00_05_00);
      rchk("kept_sec_min", 12'h168, 32'h0000_0000);
      rchk("kept_month_year", 12'h170, 32'h0000_0001);
      rchk("kept_weekday", 12'h174, 32'h0000_0006);
      apb(1'b1, 12'h168, rd, err, t1);
      chk("write_err", {31'h0, err}, 32'h1);
      rchk("write_kept", 12'h168, 32'h0000_0000);
      apb(1'b0, 12'h008, rd, err, t1);
      chk("unmapped_err", {31'h0, err}, 32'h1);
      chk("unmapped_data", rd, 32'h0);
      apb(1'b0, 12'h001, rd, err, t1);
      chk("misaligned_err", {31'h0, err}, 32'h1);
      chk("misaligned_data", rd, 32'h0);
      $display("test refusal done");
      end_sim;
   end

   // whole run is about 4500 cycles
   initial
   begin
      #(25 * 20000);
      n_errors++;
      end_sim;
   end

endmodule
